// ==== nco_pkg.sv ====
// Overview of operation
// - Phase accumulator adds increment, wraps, drops carry.
// - Increment is centre plus offset, modulo 2^32.
// - Phase carry output is inverted adder overflow.
// - Timer accumulator adds step; overflow drives carry.
// - Offset added to upper sixteen accumulator bits.
// - Host word captured while select, strobe low.
// - Target select picks low, high, phase, reserved.
// - High and low words form shared load source.
// - Centre load enable registered, loads edge later.
// - Phase input copied when registered enable low and phase source select high.
// - Quadrant code gives top offset bits, rest zero.
// - Offset gate removes offset from increment only.
// - Accumulator load zeroes phase feedback path.
// - Range select limits argument to pi or 2pi.
// - Timer step loads while its enable low.
// - Timer init zeroes timer feedback, suppressing carries.
// - Timer init bypasses lookup with raw phase.
// - Bypass: upper phase on sine, lower on cosine.
// - Lookup uses upper twenty argument bits, sixteen-bit outputs.
// - Address zero is zero radians, counterclockwise rotation.
// - Lookup outputs confined to 8001 through 7FFF; bypass passes raw phase bits.
package nco_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int PHASE_W = 32;
  localparam int ADDR_W = 20;
  localparam int TRIG_W = 16;
  localparam int QUAD_LOW_W = 14;
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_W = 31;
  // ----------------------------------------
  // Host target decode
  // ----------------------------------------
  localparam logic [1:0] SEL_FREQ_LOW = 2'h0;
  localparam logic [1:0] SEL_FREQ_HIGH = 2'h1;
  localparam logic [1:0] SEL_PHASE = 2'h2;
  localparam logic [1:0] SEL_RESERVED = 2'h3;
  // ----------------------------------------
  // Quadrant keying
  // ----------------------------------------
  localparam logic [1:0] QUAD_CODE_0 = 2'h0;
  localparam logic [1:0] QUAD_CODE_90 = 2'h1;
  localparam logic [1:0] QUAD_CODE_270 = 2'h2;
  localparam logic [1:0] QUAD_CODE_180 = 2'h3;
  localparam logic [1:0] QUAD_TOP_0 = 2'h0;
  localparam logic [1:0] QUAD_TOP_90 = 2'h1;
  localparam logic [1:0] QUAD_TOP_180 = 2'h2;
  localparam logic [1:0] QUAD_TOP_270 = 2'h3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [15:0] RESET_HALF = 16'h0000;
  // Active-low controls idle high, host port idle
  localparam logic [30:0] SYNC_IDLE = 31'h00007F1F;
  // ----------------------------------------
  // Sine/cosine generator
  // ----------------------------------------
  localparam int CORDIC_STAGES = 16;
  localparam int CORDIC_W = 18;
  localparam int ANGLE_W = 21;
  localparam logic signed [17:0] CORDIC_GAIN = 18'sh04DBA;
  localparam logic signed [15:0] TRIG_MAX = 16'sh7FFF;
  localparam logic signed [15:0] TRIG_MIN = 16'sh8001;
  // Arctangent of 2^-i, full circle = 2^20
  localparam logic [20:0] ATAN_TABLE [16] = '{
    21'h020000, 21'h012E40, 21'h009FB4, 21'h005111,
    21'h0028B1, 21'h00145D, 21'h000A2F, 21'h000518,
    21'h00028C, 21'h000146, 21'h0000A3, 21'h000051,
    21'h000029, 21'h000014, 21'h00000A, 21'h000005
  };
endpackage

// ==== nco_trig_if.sv ====
`timescale 1ns/100ps
interface nco_trig_if;
  logic [nco_pkg::ADDR_W-1:0] addr;
  logic signed [nco_pkg::TRIG_W-1:0] sine;
  logic signed [nco_pkg::TRIG_W-1:0] cosine;
  modport source (
    output addr,
    input sine,
    input cosine
  );
  modport lookup (
    input addr,
    output sine,
    output cosine
  );
endinterface

// ==== nco_sync.sv ====
`timescale 1ns/100ps
module nco_sync #(
  parameter int WIDTH = nco_pkg::SYNC_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else if (clk_en) begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule

// ==== nco_sincos.sv ====
`timescale 1ns/100ps
module nco_sincos #(
  parameter int STAGES = nco_pkg::CORDIC_STAGES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  nco_trig_if.lookup trig
);
  localparam int W = nco_pkg::CORDIC_W;
  localparam int A = nco_pkg::ANGLE_W;

  logic signed [W-1:0] x [STAGES+1];
  logic signed [W-1:0] y [STAGES+1];
  logic signed [A-1:0] z [STAGES+1];
  logic [1:0] quad [STAGES+1];
  logic signed [nco_pkg::TRIG_W-1:0] next_sine;
  logic signed [nco_pkg::TRIG_W-1:0] next_cosine;

  // Symmetric clamp, never yields 8000
  function automatic logic signed [15:0] nco_clamp(input logic signed [17:0] v);
    if (v > 18'(nco_pkg::TRIG_MAX)) begin
      nco_clamp = nco_pkg::TRIG_MAX;
    end else if (v < 18'(nco_pkg::TRIG_MIN)) begin
      nco_clamp = nco_pkg::TRIG_MIN;
    end else begin
      nco_clamp = v[15:0];
    end
  endfunction

  // ----------------------------------------
  // Rotation pipeline
  // ----------------------------------------
  // Residual below 90 degrees; quadrant restored after rotation
  assign x[0] = nco_pkg::CORDIC_GAIN;
  assign y[0] = '0;
  assign z[0] = A'({1'b0, trig.addr[17:0]});
  assign quad[0] = trig.addr[19:18];

  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    logic signed [W-1:0] next_x;
    logic signed [W-1:0] next_y;
    logic signed [A-1:0] next_z;
    always_comb begin
      if (z[i] >= 0) begin
        next_x = x[i] - (y[i] >>> i);
        next_y = y[i] + (x[i] >>> i);
        next_z = z[i] - $signed(nco_pkg::ATAN_TABLE[i]);
      end else begin
        next_x = x[i] + (y[i] >>> i);
        next_y = y[i] - (x[i] >>> i);
        next_z = z[i] + $signed(nco_pkg::ATAN_TABLE[i]);
      end
    end
    always_ff @(posedge clk) begin
      if (!resetn) begin
        x[i+1] <= '0;
        y[i+1] <= '0;
        z[i+1] <= '0;
        quad[i+1] <= 2'h0;
      end else if (clk_en) begin
        x[i+1] <= next_x;
        y[i+1] <= next_y;
        z[i+1] <= next_z;
        quad[i+1] <= quad[i];
      end
    end
  end

  // ----------------------------------------
  // Quadrant restore and clamp
  // ----------------------------------------
  always_comb begin
    unique case (quad[STAGES])
      2'h0: begin
        next_cosine = nco_clamp(x[STAGES]);
        next_sine = nco_clamp(y[STAGES]);
      end
      2'h1: begin
        next_cosine = nco_clamp(-y[STAGES]);
        next_sine = nco_clamp(x[STAGES]);
      end
      2'h2: begin
        next_cosine = nco_clamp(-x[STAGES]);
        next_sine = nco_clamp(-y[STAGES]);
      end
      2'h3: begin
        next_cosine = nco_clamp(y[STAGES]);
        next_sine = nco_clamp(-x[STAGES]);
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig.sine <= nco_pkg::RESET_HALF;
      trig.cosine <= nco_pkg::RESET_HALF;
    end else if (clk_en) begin
      trig.sine <= next_sine;
      trig.cosine <= next_cosine;
    end
  end
endmodule

// ==== nco_top.sv ====
`timescale 1ns/100ps
module nco_top #(
  parameter int CORDIC_STAGES = nco_pkg::CORDIC_STAGES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [15:0] host_word_bus,
  input wire logic [1:0] target_select,
  input wire logic chip_select_n,
  input wire logic store_strobe_n,
  input wire logic center_step_load_n,
  input wire logic offset_step_load_n,
  input wire logic phase_offset_load_n,
  input wire logic phase_source_select,
  input wire logic [1:0] quadrant_code,
  input wire logic offset_gate_n,
  input wire logic accum_load_n,
  input wire logic phase_range_select,
  input wire logic timer_step_load_n,
  input wire logic timer_init_bypass_n,
  output logic phase_carry_n,
  output logic timer_carry_n,
  output logic [31:0] phase_argument,
  output logic [15:0] sine_out,
  output logic [15:0] cosine_out
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [nco_pkg::SYNC_W-1:0] pins_async;
  logic [nco_pkg::SYNC_W-1:0] pins_sync;
  logic [15:0] s_word;
  logic [1:0] s_target;
  logic s_cs_n;
  logic s_strobe_n;
  logic s_center_ld_n;
  logic s_offset_ld_n;
  logic s_phase_ld_n;
  logic s_phase_src;
  logic [1:0] s_quad;
  logic s_gate_n;
  logic s_accum_ld_n;
  logic s_range;
  logic s_timer_ld_n;
  logic s_bypass_n;

  assign pins_async = {host_word_bus, target_select, chip_select_n, store_strobe_n,
                       center_step_load_n, offset_step_load_n, phase_offset_load_n,
                       phase_source_select, quadrant_code, offset_gate_n, accum_load_n,
                       phase_range_select, timer_step_load_n, timer_init_bypass_n};

  nco_sync #(
    .WIDTH(nco_pkg::SYNC_W),
    .RESET_VALUE(nco_pkg::SYNC_IDLE)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign {s_word, s_target, s_cs_n, s_strobe_n, s_center_ld_n, s_offset_ld_n,
          s_phase_ld_n, s_phase_src, s_quad, s_gate_n, s_accum_ld_n, s_range,
          s_timer_ld_n, s_bypass_n} = pins_sync;

  // ----------------------------------------
  // Host input registers
  // ----------------------------------------
  logic [15:0] freq_low;
  logic [15:0] freq_high;
  logic [15:0] phase_input;
  logic [15:0] next_freq_low;
  logic [15:0] next_freq_high;
  logic [15:0] next_phase_input;
  logic host_write;
  logic [31:0] freq_word;

  assign host_write = !s_cs_n && !s_strobe_n;
  assign freq_word = {freq_high, freq_low};

  always_comb begin
    next_freq_low = freq_low;
    next_freq_high = freq_high;
    next_phase_input = phase_input;
    if (host_write) begin
      unique case (s_target)
        nco_pkg::SEL_FREQ_LOW: next_freq_low = s_word;
        nco_pkg::SEL_FREQ_HIGH: next_freq_high = s_word;
        nco_pkg::SEL_PHASE: next_phase_input = s_word;
        nco_pkg::SEL_RESERVED: next_phase_input = phase_input;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      freq_low <= nco_pkg::RESET_HALF;
      freq_high <= nco_pkg::RESET_HALF;
      phase_input <= nco_pkg::RESET_HALF;
    end else if (clk_en) begin
      freq_low <= next_freq_low;
      freq_high <= next_freq_high;
      phase_input <= next_phase_input;
    end
  end

  // ----------------------------------------
  // Frequency, timer and phase offset registers
  // ----------------------------------------
  logic center_load_registered;
  logic offset_load_registered;
  logic phase_offset_load_registered;
  logic [31:0] center_freq;
  logic [31:0] offset_freq;
  logic [31:0] timer_step;
  logic [15:0] phase_offset;
  logic [31:0] next_center_freq;
  logic [31:0] next_offset_freq;
  logic [31:0] next_timer_step;
  logic [15:0] next_phase_offset;

  always_comb begin
    next_center_freq = center_freq;
    next_offset_freq = offset_freq;
    next_timer_step = timer_step;
    next_phase_offset = phase_offset;
    if (!center_load_registered) begin
      next_center_freq = freq_word;
    end
    if (!offset_load_registered) begin
      next_offset_freq = freq_word;
    end
    if (!s_timer_ld_n) begin
      next_timer_step = freq_word;
    end
    if (!phase_offset_load_registered) begin
      if (s_phase_src) begin
        next_phase_offset = phase_input;
      end else begin
        unique case (s_quad)
          nco_pkg::QUAD_CODE_0: next_phase_offset = {nco_pkg::QUAD_TOP_0, 14'h0000};
          nco_pkg::QUAD_CODE_90: next_phase_offset = {nco_pkg::QUAD_TOP_90, 14'h0000};
          nco_pkg::QUAD_CODE_270: next_phase_offset = {nco_pkg::QUAD_TOP_270, 14'h0000};
          nco_pkg::QUAD_CODE_180: next_phase_offset = {nco_pkg::QUAD_TOP_180, 14'h0000};
        endcase
      end
    end
  end

  // Registered enables add the documented one-edge delay
  always_ff @(posedge clk) begin
    if (!resetn) begin
      center_load_registered <= 1'b1;
      offset_load_registered <= 1'b1;
      phase_offset_load_registered <= 1'b1;
      center_freq <= nco_pkg::RESET_WORD;
      offset_freq <= nco_pkg::RESET_WORD;
      timer_step <= nco_pkg::RESET_WORD;
      phase_offset <= nco_pkg::RESET_HALF;
    end else if (clk_en) begin
      center_load_registered <= s_center_ld_n;
      offset_load_registered <= s_offset_ld_n;
      phase_offset_load_registered <= s_phase_ld_n;
      center_freq <= next_center_freq;
      offset_freq <= next_offset_freq;
      timer_step <= next_timer_step;
      phase_offset <= next_phase_offset;
    end
  end

  // ----------------------------------------
  // Phase and timer accumulators
  // ----------------------------------------
  logic [31:0] phase_acc;
  logic [31:0] timer_acc;
  logic [31:0] phase_incr;
  logic [31:0] phase_feedback;
  logic [31:0] timer_feedback;
  logic [32:0] phase_sum;
  logic [32:0] timer_sum;
  logic [31:0] next_phase_acc;
  logic [31:0] next_timer_acc;
  logic next_phase_carry_n;
  logic next_timer_carry_n;

  always_comb begin
    phase_incr = center_freq + (s_gate_n ? offset_freq : 32'h00000000);
    phase_feedback = s_accum_ld_n ? phase_acc : 32'h00000000;
    timer_feedback = s_bypass_n ? timer_acc : 32'h00000000;
    phase_sum = {1'b0, phase_feedback} + {1'b0, phase_incr};
    timer_sum = {1'b0, timer_feedback} + {1'b0, timer_step};
    next_phase_acc = phase_sum[31:0];
    next_timer_acc = timer_sum[31:0];
    next_phase_carry_n = !phase_sum[32];
    next_timer_carry_n = !timer_sum[32];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_acc <= nco_pkg::RESET_WORD;
      timer_acc <= nco_pkg::RESET_WORD;
      phase_carry_n <= 1'b1;
      timer_carry_n <= 1'b1;
    end else if (clk_en) begin
      phase_acc <= next_phase_acc;
      timer_acc <= next_timer_acc;
      phase_carry_n <= next_phase_carry_n;
      timer_carry_n <= next_timer_carry_n;
    end
  end

  // ----------------------------------------
  // Phase adder and range
  // ----------------------------------------
  logic [31:0] next_phase_argument;
  logic [15:0] offset_top;

  always_comb begin
    offset_top = phase_acc[31:16] + phase_offset;
    next_phase_argument = {offset_top, phase_acc[15:0]};
    if (!s_range) begin
      next_phase_argument[31] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_argument <= nco_pkg::RESET_WORD;
    end else if (clk_en) begin
      phase_argument <= next_phase_argument;
    end
  end

  // ----------------------------------------
  // Sine/cosine lookup and bypass
  // ----------------------------------------
  nco_trig_if trig ();
  logic [15:0] next_sine_out;
  logic [15:0] next_cosine_out;

  assign trig.addr = phase_argument[31:12];

  nco_sincos #(
    .STAGES(CORDIC_STAGES)
  ) u_sincos (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .trig(trig)
  );

  // Bypass is immediate; lookup path lags by pipeline depth
  always_comb begin
    if (!s_bypass_n) begin
      next_sine_out = phase_argument[31:16];
      next_cosine_out = phase_argument[15:0];
    end else begin
      next_sine_out = trig.sine;
      next_cosine_out = trig.cosine;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sine_out <= nco_pkg::RESET_HALF;
      cosine_out <= nco_pkg::RESET_HALF;
    end else if (clk_en) begin
      sine_out <= next_sine_out;
      cosine_out <= next_cosine_out;
    end
  end
endmodule

// ==== nco_assertions.sv ====
`timescale 1ns/100ps
module nco_assertions #(
  parameter int CORDIC_STAGES = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic center_step_load_n,
  input wire logic offset_step_load_n,
  input wire logic phase_offset_load_n,
  input wire logic offset_gate_n,
  input wire logic accum_load_n,
  input wire logic phase_range_select,
  input wire logic timer_init_bypass_n,
  input wire logic phase_carry_n,
  input wire logic timer_carry_n,
  input wire logic [31:0] phase_argument,
  input wire logic [15:0] sine_out,
  input wire logic [15:0] cosine_out
);
  // ----
  // Quiet counter
  // ----
  // Threshold covers sync, enable register, load and argument stages
  logic [3:0] quiet_cnt;
  logic [3:0] next_quiet_cnt;
  logic range_q;
  logic quiet;
  assign quiet = clk_en && !accum_load_n && !offset_gate_n && center_step_load_n
    && offset_step_load_n && phase_offset_load_n && (phase_range_select == range_q);
  always_comb begin
    next_quiet_cnt = 4'h0;
    if (resetn && quiet) begin
      next_quiet_cnt = (quiet_cnt == 4'hF) ? quiet_cnt : quiet_cnt + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    quiet_cnt <= next_quiet_cnt;
    range_q <= phase_range_select;
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_bypass_held;
    (!timer_init_bypass_n && clk_en) [*4];
  endsequence
  sequence s_lookup_held;
    (timer_init_bypass_n && clk_en) [*4];
  endsequence
  chk_reset_clear: assert property (
    $rose(resetn) && $past(clk_en) |-> phase_carry_n && timer_carry_n
      && phase_argument == 32'h00000000 && sine_out == 16'h0000 && cosine_out == 16'h0000)
    else $error("outputs not cleared by reset");
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(phase_argument) && $stable(sine_out) && $stable(phase_carry_n))
    else $error("state moved while clock enable low");
  chk_range_pi: assert property (
    (!phase_range_select && clk_en) [*4] |=> !phase_argument[31])
    else $error("argument beyond half circle");
  chk_bypass_sine: assert property (
    s_bypass_held |=> sine_out == $past(phase_argument[31:16]))
    else $error("bypass upper half wrong");
  chk_bypass_cosine: assert property (
    s_bypass_held |=> cosine_out == $past(phase_argument[15:0]))
    else $error("bypass lower half wrong");
  chk_timer_quiet: assert property (
    s_bypass_held |=> timer_carry_n)
    else $error("timer carry during init");
  chk_trig_range: assert property (
    s_lookup_held |=> sine_out != 16'h8000 && cosine_out != 16'h8000)
    else $error("lookup produced most negative code");
  chk_accum_hold: assert property (
    quiet_cnt >= 4'hA |-> $stable(phase_argument))
    else $error("argument moved with feedback zeroed");
endmodule

bind nco_top nco_assertions #(.CORDIC_STAGES(CORDIC_STAGES)) u_chk (.clk, .resetn, .clk_en,
  .center_step_load_n, .offset_step_load_n, .phase_offset_load_n, .offset_gate_n,
  .accum_load_n, .phase_range_select, .timer_init_bypass_n, .phase_carry_n,
  .timer_carry_n, .phase_argument, .sine_out, .cosine_out);

// ==== nco_host_model.sv ====
`timescale 1ns/100ps
module nco_host_model (
  input wire logic clk,
  output logic [15:0] host_word_bus,
  output logic [1:0] target_select,
  output logic chip_select_n,
  output logic store_strobe_n
);
  initial begin
    host_word_bus = 16'h0000;
    target_select = 2'h3;
    chip_select_n = 1'b1;
    store_strobe_n = 1'b1;
  end
  // ----
  // Write cycle
  // ----
  // One cycle low; afterwards the bus shows the inverse, never the old word
  task automatic write_word(input logic cs_n, input logic [1:0] sel, input logic [15:0] w);
    @(negedge clk);
    host_word_bus = w;
    target_select = sel;
    chip_select_n = cs_n;
    store_strobe_n = 1'b0;
    @(negedge clk);
    chip_select_n = 1'b1;
    store_strobe_n = 1'b1;
    host_word_bus = ~w;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic center_step_load_n = 1'b1;
  logic offset_step_load_n = 1'b1;
  logic phase_offset_load_n = 1'b1;
  logic phase_source_select = 1'b0;
  logic [1:0] quadrant_code = 2'h0;
  logic offset_gate_n = 1'b1;
  logic accum_load_n = 1'b1;
  logic phase_range_select = 1'b1;
  logic timer_step_load_n = 1'b1;
  logic timer_init_bypass_n = 1'b1;
  logic [15:0] host_word_bus;
  logic [1:0] target_select;
  logic chip_select_n, store_strobe_n, phase_carry_n, timer_carry_n;
  logic [31:0] phase_argument;
  logic [15:0] sine_out, cosine_out;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] quad_top [4] = '{16'h0000, 16'h4000, 16'hC000, 16'h8000};
  int sin_exp [4] = '{0, 32767, -32767, 0};
  int cos_exp [4] = '{32767, 0, 0, -32767};

  always #4 clk = ~clk;

  nco_host_model u_host (.clk, .host_word_bus, .target_select, .chip_select_n,
    .store_strobe_n);
  nco_top u_dut (.clk, .resetn, .clk_en, .host_word_bus, .target_select, .chip_select_n,
    .store_strobe_n, .center_step_load_n, .offset_step_load_n, .phase_offset_load_n,
    .phase_source_select, .quadrant_code, .offset_gate_n, .accum_load_n,
    .phase_range_select, .timer_step_load_n, .timer_init_bypass_n, .phase_carry_n,
    .timer_carry_n, .phase_argument, .sine_out, .cosine_out);

  // ----
  // Helpers
  // ----
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Lookup is approximate, so a small window is allowed
  task automatic near(input logic [15:0] got, input int exp);
    int d;
    d = int'($signed(got)) - exp;
    n_compared++;
    if ($isunknown(got) || got === 16'h8000 || d > 4 || d < -4) begin
      err_total++;
      $display("[FAIL] %0t trig %h exp %0d", $time, got, exp);
    end
  endtask
  task automatic load_word(input logic [31:0] w);
    u_host.write_word(1'b0, 2'h0, w[15:0]);
    u_host.write_word(1'b0, 2'h1, w[31:16]);
  endtask
  task automatic pulse(ref logic sig);
    step(1);
    sig = 1'b0;
    step(1);
    sig = 1'b1;
    step(8);
  endtask
  task automatic incr(input logic [31:0] exp);
    logic [31:0] a;
    a = phase_argument;
    step(1);
    check(phase_argument - a, exp);
  endtask
  task automatic count_low(input logic timer, output int c);
    c = 0;
    repeat (16) begin
      step(1);
      if ((timer ? timer_carry_n : phase_carry_n) === 1'b0) c++;
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end

  // ----
  // Tests
  // ----
  initial begin
    int c;
    step(4);
    resetn = 1'b1;
    step(2);
    load_word(32'h00000001);
    u_host.write_word(1'b0, 2'h3, 16'hFFFF);
    u_host.write_word(1'b1, 2'h0, 16'hFFFF);
    pulse(center_step_load_n);
    accum_load_n = 1'b0;
    step(8);
    check(phase_argument, 32'h00000001);
    accum_load_n = 1'b1;
    step(6);
    incr(32'h00000001);
    clk_en = 1'b0;
    step(3);
    clk_en = 1'b1;
    step(1);
    incr(32'h00000001);
    load_word(32'h40000000);
    pulse(center_step_load_n);
    accum_load_n = 1'b0;
    step(6);
    accum_load_n = 1'b1;
    step(4);
    count_low(1'b0, c);
    check(c, 4);
    load_word(32'h00000002);
    pulse(offset_step_load_n);
    load_word(32'hFFFFFFFF);
    pulse(center_step_load_n);
    incr(32'h00000001);
    offset_gate_n = 1'b0;
    step(6);
    incr(32'hFFFFFFFF);
    offset_gate_n = 1'b1;
    step(6);
    incr(32'h00000001);
    offset_gate_n = 1'b0;
    load_word(32'h00010002);
    pulse(center_step_load_n);
    u_host.write_word(1'b0, 2'h2, 16'h1234);
    u_host.write_word(1'b0, 2'h3, 16'hFFFF);
    phase_source_select = 1'b1;
    accum_load_n = 1'b0;
    pulse(phase_offset_load_n);
    check(phase_argument, 32'h12350002);
    phase_source_select = 1'b0;
    for (int i = 0; i < 4; i++) begin
      quadrant_code = i[1:0];
      pulse(phase_offset_load_n);
      check(phase_argument, {16'h0001 + quad_top[i], 16'h0002});
    end
    phase_range_select = 1'b0;
    step(14);
    check(phase_argument, 32'h00010002);
    phase_range_select = 1'b1;
    load_word(32'h40000000);
    pulse(timer_step_load_n);
    count_low(1'b1, c);
    check(c, 4);
    timer_init_bypass_n = 1'b0;
    step(8);
    count_low(1'b1, c);
    check(c, 0);
    check({sine_out, cosine_out}, 32'h80010002);
    timer_init_bypass_n = 1'b1;
    load_word(32'h00000000);
    pulse(center_step_load_n);
    for (int i = 0; i < 4; i++) begin
      quadrant_code = i[1:0];
      pulse(phase_offset_load_n);
      step(24);
      near(sine_out, sin_exp[i]);
      near(cosine_out, cos_exp[i]);
    end
    step(2);
    final_report();
  end
endmodule
